// ### src/hb_decode_params.svh
/*
  Constants for the three-channel half-bridge load decode: channel count,
  mode encodings and reset values as `define macros.
  Assumes inclusion by bare name from the design sources.
*/
`ifndef HB_DECODE_PARAMS_SVH
`define HB_DECODE_PARAMS_SVH

`define HB_CHANNELS        3
`define HB_MODE_6X         2'h0
`define HB_MODE_3X         2'h1
`define HB_MODE_6X_LIMIT   2'h2
`define HB_MODE_3X_LIMIT   2'h3
`define HB_RESET_LEVEL     1'h0
`define HB_RESET_OE_N      1'h1

`endif

// ### src/hb_decode_pkg.sv
/*
  Types for the half-bridge load decode: control mode enum, per-channel
  drive struct and the state record of a channel.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hb_decode_pkg;

  typedef enum logic [1:0] {
    mode_6x       = 2'h0,
    mode_3x       = 2'h1,
    mode_6x_limit = 2'h2,
    mode_3x_limit = 2'h3
  } control_mode_t;

  // what one half-bridge drives onto its pin
  typedef struct packed {
    logic level;
    logic oe_n;
  } pin_drive_t;

  // registered state of one channel
  typedef struct packed {
    pin_drive_t drive;
    logic       sense_valid;
    logic       limit_active;
  } channel_state_t;

endpackage

// ### src/half_bridge_channel.sv
/*
  One half-bridge channel: decodes its own phase_input and phase_enable
  into a registered pin drive, plus sense and limit availability flags.
  Assumes inputs synchronous to clock_in and a synchronous low reset.
*/
`timescale 1ns/1ps
`include "hb_decode_params.svh"

module half_bridge_channel (
  input  wire logic                          clock_in,
  input  wire logic                          resetn_in,
  input  wire logic                          phase_input_in,
  input  wire logic                          phase_enable_in,
  input  wire logic                          load_to_ground_in,
  input  wire logic                          limit_mode_in,
  output logic                               drive_level_out,
  output logic                               drive_oe_n_out,
  output logic                               sense_valid_out,
  output logic                               limit_active_out
);

  hb_decode_pkg::channel_state_t state;
  hb_decode_pkg::channel_state_t next_state;

  // decode looks only at this channel's pins; full bridge is host made
  always_comb begin
    next_state = state;
    if (phase_enable_in) begin
      next_state.drive.oe_n  = 1'h0;
      next_state.drive.level = phase_input_in;
    end else begin
      next_state.drive.oe_n  = `HB_RESET_OE_N;
      next_state.drive.level = `HB_RESET_LEVEL;
    end
    // sense only while current returns through the low-side switch;
    // a grounded load sources through the high side so none is offered
    next_state.sense_valid = phase_enable_in && !phase_input_in
                             && !load_to_ground_in;
    next_state.limit_active = limit_mode_in && phase_enable_in
                              && !load_to_ground_in;
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      state.drive.level  <= `HB_RESET_LEVEL;
      state.drive.oe_n   <= `HB_RESET_OE_N;
      state.sense_valid  <= 1'h0;
      state.limit_active <= 1'h0;
    end else begin
      state <= next_state;
    end
  end

  assign drive_level_out  = state.drive.level;
  assign drive_oe_n_out   = state.drive.oe_n;
  assign sense_valid_out  = state.sense_valid;
  assign limit_active_out = state.limit_active;

  // pin follows input one cycle later while enabled
  drive_follow_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in
    |=> !drive_oe_n_out && drive_level_out == $past(phase_input_in))
    else $error("enabled channel did not follow its input");

  // disabled channel floats next cycle
  disable_float_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !phase_enable_in |=> drive_oe_n_out)
    else $error("disabled channel still driving");

  // grounded load never gets sense or limit
  ground_no_sense_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    load_to_ground_in |=> !sense_valid_out && !limit_active_out)
    else $error("sense or limit offered for grounded load");

  // sense flag only with low side on
  sense_lowside_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    sense_valid_out |-> !drive_oe_n_out && !drive_level_out)
    else $error("sense reported without low side conducting");

endmodule

// ### src/half_bridge_load_decode.sv
/*
  Top of the three-channel half-bridge load decode used for brushed motors
  and solenoids; one channel instance per phase, generated in a loop.
  Assumes an outside controller drives phase inputs, enables, control mode
  and current_limit_trip_in; pin levels are resolved by the surroundings.
*/
`timescale 1ns/1ps
`include "hb_decode_params.svh"

module half_bridge_load_decode #(
  parameter int CHANNELS = `HB_CHANNELS
) (
  input  wire logic                          clock_in,
  input  wire logic                          resetn_in,
  input  wire logic [1:0]                    control_mode_in,
  input  wire logic [CHANNELS-1:0]           phase_input_in,
  input  wire logic [CHANNELS-1:0]           phase_enable_in,
  input  wire logic [CHANNELS-1:0]           load_to_ground_in,
  input  wire logic [CHANNELS-1:0]           current_limit_trip_in,
  output logic      [CHANNELS-1:0]           phase_output_out,
  output logic      [CHANNELS-1:0]           phase_output_oe_n_out,
  output logic      [CHANNELS-1:0]           current_sense_valid_out,
  output logic      [CHANNELS-1:0]           current_limit_chop_out
);

  hb_decode_pkg::control_mode_t mode;
  logic                         limit_mode;
  logic [CHANNELS-1:0]          limit_active;

  // all four modes behave the same for the decode itself
  assign mode       = hb_decode_pkg::control_mode_t'(control_mode_in);
  assign limit_mode = (mode == hb_decode_pkg::mode_6x_limit)
                      || (mode == hb_decode_pkg::mode_3x_limit);

  // channels are fully independent, so three solenoids need no sharing
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
      half_bridge_channel u_channel (
        .clock_in          (clock_in),
        .resetn_in         (resetn_in),
        .phase_input_in    (phase_input_in[ch]),
        .phase_enable_in   (phase_enable_in[ch]),
        .load_to_ground_in (load_to_ground_in[ch]),
        .limit_mode_in     (limit_mode),
        .drive_level_out   (phase_output_out[ch]),
        .drive_oe_n_out    (phase_output_oe_n_out[ch]),
        .sense_valid_out   (current_sense_valid_out[ch]),
        .limit_active_out  (limit_active[ch])
      );
    end
  endgenerate

  // chop request: comparator trip against the host-set limit level,
  // honoured only where the limit is available
  assign current_limit_chop_out = limit_active & current_limit_trip_in;

  // forward pair decode
  pair_forward_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in[1:0] == 2'h3 && phase_input_in[1:0] == 2'h1
    |=> phase_output_out[1:0] == 2'h1
        && phase_output_oe_n_out[1:0] == 2'h0)
    else $error("forward decode wrong");

  // reverse pair decode
  pair_reverse_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in[1:0] == 2'h3 && phase_input_in[1:0] == 2'h2
    |=> phase_output_out[1:0] == 2'h2
        && phase_output_oe_n_out[1:0] == 2'h0)
    else $error("reverse decode wrong");

  // low-side brake
  pair_brake_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in[1:0] == 2'h3 && phase_input_in[1:0] == 2'h0
    |=> phase_output_out[1:0] == 2'h0
        && phase_output_oe_n_out[1:0] == 2'h0)
    else $error("brake decode wrong");

  // high-side slow decay
  pair_highdecay_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in[1:0] == 2'h3 && phase_input_in[1:0] == 2'h3
    |=> phase_output_out[1:0] == 2'h3
        && phase_output_oe_n_out[1:0] == 2'h0)
    else $error("high-side decay decode wrong");

  // coast holds as long as enables stay low
  pair_coast_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in[1:0] == 2'h0 [*2]
    |=> phase_output_oe_n_out[1:0] == 2'h3)
    else $error("coast did not float both outputs");

  // no chop outside limit modes
  chop_mode_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    !limit_mode ##1 !limit_mode |-> current_limit_chop_out == '0)
    else $error("chop outside a limit mode");

  // chop never on channel 2 while its load is grounded and the wiring holds
  chop_ground_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    $stable(load_to_ground_in) && load_to_ground_in[2]
    |-> !current_limit_chop_out[2])
    else $error("chop on grounded load");

  // independence: channel 2 ignores channel 0 and 1 inputs
  chan_independent_a : assert property (
    @(posedge clock_in) disable iff (!resetn_in)
    phase_enable_in[2]
    |=> phase_output_out[2] == $past(phase_input_in[2]))
    else $error("channel 2 decode disturbed");

  forward_seen_c : cover property (@(posedge clock_in) disable iff (!resetn_in)
    phase_output_out[1:0] == 2'h1 && phase_output_oe_n_out[1:0] == 2'h0);
  reverse_seen_c : cover property (@(posedge clock_in) disable iff (!resetn_in)
    phase_output_out[1:0] == 2'h2 && phase_output_oe_n_out[1:0] == 2'h0);
  coast_seen_c : cover property (@(posedge clock_in) disable iff (!resetn_in)
    phase_output_oe_n_out == '1);
  chop_seen_c : cover property (@(posedge clock_in) disable iff (!resetn_in)
    current_limit_chop_out != '0);

endmodule

// ### verification/host_controller_model.sv
/*
  Host controller model: drives phase inputs, enables, control mode, load
  wiring and limit trips of the decode. Assumes the bench calls drive_pins.
*/
`timescale 1ns/1ps
module host_controller_model (
  input  wire logic       clock_in,
  output logic [1:0]      control_mode_out,
  output logic [2:0]      phase_input_out,
  output logic [2:0]      phase_enable_out,
  output logic [2:0]      load_to_ground_out,
  output logic [2:0]      limit_trip_out
);
  // pins move on the falling edge, well away from the sampling edge
  task automatic drive_pins(input logic [1:0] mode,
                            input logic [2:0] inp, en, gnd, trip);
    @(negedge clock_in);
    control_mode_out   = mode;
    phase_input_out    = inp;
    phase_enable_out   = en;
    load_to_ground_out = gnd;
    limit_trip_out     = trip;
  endtask

  // quiet, all channels floating until the bench asks for more
  initial begin
    control_mode_out   = 2'h0;
    phase_input_out    = 3'h0;
    phase_enable_out   = 3'h0;
    load_to_ground_out = 3'h0;
    limit_trip_out     = 3'h0;
  end
endmodule

// ### verification/tb.sv
/*
  Self-checking bench for the three-channel half-bridge load decode.
  Assumes the host model as stimulus source and a 25 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  logic       clock_in;
  logic       resetn_in;
  logic [1:0] mode;
  logic [2:0] inp, en, gnd, trip, lvl, oe_n, sense, chop;
  int         miscompares;
  int         tests_run;

  half_bridge_load_decode u_half_bridge_load_decode (
    .clock_in(clock_in), .resetn_in(resetn_in), .control_mode_in(mode),
    .phase_input_in(inp), .phase_enable_in(en), .load_to_ground_in(gnd),
    .current_limit_trip_in(trip), .phase_output_out(lvl),
    .phase_output_oe_n_out(oe_n), .current_sense_valid_out(sense),
    .current_limit_chop_out(chop));

  host_controller_model u_host_controller_model (
    .clock_in(clock_in), .control_mode_out(mode), .phase_input_out(inp),
    .phase_enable_out(en), .load_to_ground_out(gnd),
    .limit_trip_out(trip));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  task automatic tally_and_finish;
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic compare(input logic [11:0] want);
    tests_run++;
    if ({lvl, oe_n, sense, chop} !== want) begin
      miscompares++;
      $display("Error at %0t: outputs %h, expected %h", $time,
               {lvl, oe_n, sense, chop}, want);
    end
  endtask

  // drive one setting, then judge it a half cycle after the sampling edge
  task automatic apply(input logic [1:0] m, input logic [2:0] i, e, g, t);
    logic [2:0] s;
    u_host_controller_model.drive_pins(m, i, e, g, t);
    @(negedge clock_in);
    s = e & ~i & ~g;
    compare({i & e, ~e, s, m[1] ? (e & ~g & t) : 3'h0});
  endtask

  task automatic bridge_table;
    for (int k = 0; k < 4; k++)
      apply(2'h0, {1'b0, k[0], k[1]}, 3'h3, 3'h0, 3'h0);
    apply(2'h1, 3'h3, 3'h0, 3'h0, 3'h0);
    apply(2'h0, 3'h4, 3'h3, 3'h0, 3'h0);
  endtask

  task automatic solenoid_loads;
    apply(2'h0, 3'h0, 3'h4, 3'h0, 3'h0);
    apply(2'h1, 3'h4, 3'h4, 3'h0, 3'h0);
    apply(2'h0, 3'h4, 3'h4, 3'h4, 3'h0);
    apply(2'h1, 3'h0, 3'h4, 3'h4, 3'h0);
  endtask

  // every mode with three supply-tied solenoids and the limit tripped, then grounded loads and a single trip in limit modes
  task automatic limit_modes;
    for (int m = 0; m < 4; m++)
      apply(m[1:0], 3'h0, 3'h7, 3'h0, 3'h7);
    apply(2'h3, 3'h0, 3'h7, 3'h5, 3'h7);
    apply(2'h2, 3'h0, 3'h7, 3'h0, 3'h2);
  endtask

  // reset in mid-run floats everything whatever the pins ask
  task automatic reset_midrun;
    apply(2'h2, 3'h1, 3'h7, 3'h0, 3'h7);
    resetn_in = 1'b0;
    repeat (2) @(negedge clock_in);
    compare({3'h0, 3'h7, 3'h0, 3'h0});
    resetn_in = 1'b1;
    apply(2'h2, 3'h2, 3'h7, 3'h0, 3'h7);
  endtask

  // a hang counts as a mismatch and ends the run the normal way
  initial begin
    #(40 * 2000);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    miscompares = 0;
    tests_run   = 0;
    resetn_in   = 1'b0;
    repeat (5) @(negedge clock_in);
    resetn_in = 1'b1;
    bridge_table();
    solenoid_loads();
    limit_modes();
    reset_midrun();
    tally_and_finish();
  end
endmodule
